// ==== verilog/dup_pkg.sv ====
// Constants shared by the directional under-power element
package dup_pkg;
    localparam int CLK_HZ      = 25000000;
    localparam int TICK_MS     = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    localparam int REG_AW = 4;
    localparam int REG_DW = 32;

    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_ANGLE  = 4'h1;
    localparam logic [3:0] A_POWER  = 4'h2;
    localparam logic [3:0] A_DELAY  = 4'h3;
    localparam logic [3:0] A_STATUS = 4'h4;
    localparam logic [3:0] A_EVENT  = 4'h5;
    localparam logic [3:0] A_MASK   = 4'h6;
    localparam logic [3:0] A_TIMER  = 4'h7;
    localparam logic [3:0] A_PROJ   = 4'h8;

    localparam int CTRL_OP  = 0;
    localparam int CTRL_SO  = 1;
    localparam int ST_START = 0;
    localparam int ST_TRIP  = 1;
    localparam int ST_DIR   = 2;

    localparam int EV_W         = 4;
    localparam int EV_START_ON  = 0;
    localparam int EV_START_OFF = 1;
    localparam int EV_TRIP_ON   = 2;
    localparam int EV_TRIP_OFF  = 3;

    localparam logic              RST_OP   = 1'b0;
    localparam logic              RST_SO   = 1'b0;
    localparam logic signed [8:0] ANG_RST  = 9'h000;
    localparam logic signed [8:0] ANG_MIN  = 9'h14d;
    localparam logic signed [8:0] ANG_MAX  = 9'h0b4;
    localparam int                ANG_QUARTER = 90;
    localparam int                ANG_HALF    = 180;
    localparam logic [10:0]       PWR_RST  = 11'h064;
    localparam logic [10:0]       PWR_MIN  = 11'h00a;
    localparam logic [10:0]       PWR_MAX  = 11'h7d0;
    localparam logic [15:0]       DLY_RST  = 16'h00c8;
    localparam logic [15:0]       DLY_MIN  = 16'h00c8;
    localparam logic [15:0]       DLY_MAX  = 16'hea60;
    localparam logic [3:0]        MASK_RST = 4'h0;

    localparam int HYST_NUM   = 51;
    localparam int HYST_SHIFT = 10;
    localparam int GAIN_NUM   = 6745;
    localparam int GAIN_SHIFT = 12;
    localparam int CORDIC_N   = 12;
endpackage

// ==== verilog/dup_pq.sv ====
// Three-phase active and reactive power from fundamental phasors
`timescale 1ns/1ns
module dup_pq #(
    parameter int W     = 16,
    parameter int PW    = 24,
    parameter int SHIFT = 8
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     in_valid,
    input  wire logic signed [2:0][W-1:0] u_re,
    input  wire logic signed [2:0][W-1:0] u_im,
    input  wire logic signed [2:0][W-1:0] i_re,
    input  wire logic signed [2:0][W-1:0] i_im,
    output logic                          out_valid,
    output logic signed [PW-1:0]          p,
    output logic signed [PW-1:0]          q
);
    import dup_pkg::*;
    localparam int AW = 2 * W + 3;

    typedef struct packed {
        logic                 valid;
        logic signed [PW-1:0] p;
        logic signed [PW-1:0] q;
    } dup_pq_state_t;

    dup_pq_state_t        s;
    dup_pq_state_t        next_s;
    logic signed [AW-1:0] acc_p;
    logic signed [AW-1:0] acc_q;
    logic signed [AW-1:0] sh_p;
    logic signed [AW-1:0] sh_q;

    // S = U * conj(I), summed over the phases
    always_comb begin
        acc_p = '0;
        acc_q = '0;
        for (int k = 0; k < 3; k++) begin
            // Widen before multiplying so no product is cut to 16 bits
            acc_p = acc_p
                + AW'($signed(u_re[k])) * AW'($signed(i_re[k]))
                + AW'($signed(u_im[k])) * AW'($signed(i_im[k]));
            acc_q = acc_q
                + AW'($signed(u_im[k])) * AW'($signed(i_re[k]))
                - AW'($signed(u_re[k])) * AW'($signed(i_im[k]));
        end
        sh_p = acc_p >>> SHIFT;
        sh_q = acc_q >>> SHIFT;
        next_s = s;
        next_s.valid = in_valid;
        if (in_valid) begin
            next_s.p = sh_p[PW-1:0];
            next_s.q = sh_q[PW-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_valid = s.valid;
    assign p         = s.p;
    assign q         = s.q;

    a_pq_strobe: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (in_valid |=> out_valid)
        and (!in_valid |=> !out_valid && $stable(p) && $stable(q)))
        else $error("power result strobe or hold wrong");
endmodule

// ==== verilog/dup_proj.sv ====
// Projection of the power point onto the direction angle
`timescale 1ns/1ns
module dup_proj #(
    parameter int PW = 24
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 start,
    input  wire logic signed [PW-1:0] x_in,
    input  wire logic signed [PW-1:0] y_in,
    input  wire logic signed [8:0]    angle,
    output logic                      busy,
    output logic                      done,
    output logic signed [PW+1:0]      proj
);
    import dup_pkg::*;
    localparam int XW = PW + 2;

    typedef struct packed {
        logic                 busy;
        logic                 done;
        logic [3:0]           iter;
        logic signed [XW-1:0] x;
        logic signed [XW-1:0] y;
        logic signed [15:0]   z;
    } dup_proj_state_t;

    dup_proj_state_t      s;
    dup_proj_state_t      next_s;
    logic signed [9:0]    red;
    logic                 flip;
    logic signed [XW-1:0] sx;
    logic signed [XW-1:0] sy;
    logic signed [XW-1:0] xe;
    logic signed [XW-1:0] ye;

    // Arctangent of 2^-i in degrees, eight fraction bits
    function automatic logic signed [15:0] atan_q8(input logic [3:0] i);
        case (i)
            4'h0: atan_q8 = 16'sh2d00;
            4'h1: atan_q8 = 16'sh1a91;
            4'h2: atan_q8 = 16'sh0e09;
            4'h3: atan_q8 = 16'sh0720;
            4'h4: atan_q8 = 16'sh0394;
            4'h5: atan_q8 = 16'sh01ca;
            4'h6: atan_q8 = 16'sh00e5;
            4'h7: atan_q8 = 16'sh0073;
            4'h8: atan_q8 = 16'sh0039;
            4'h9: atan_q8 = 16'sh001d;
            4'ha: atan_q8 = 16'sh000e;
            4'hb: atan_q8 = 16'sh0007;
            default: atan_q8 = 16'sh0000;
        endcase
    endfunction

    // Result carries the rotation gain; the caller scales its threshold
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        flip = 1'b0;
        red = 10'(angle);
        // Fold beyond +-90 deg, where the rotation would not converge
        if (int'(angle) > ANG_QUARTER) begin
            flip = 1'b1;
            red = 10'(angle) - 10'(ANG_HALF);
        end else if (int'(angle) < -ANG_QUARTER) begin
            flip = 1'b1;
            red = 10'(angle) + 10'(ANG_HALF);
        end
        xe = XW'(x_in);
        ye = XW'(y_in);
        sx = s.x >>> s.iter;
        sy = s.y >>> s.iter;
        if (start && !s.busy) begin
            next_s.busy = 1'b1;
            next_s.iter = 4'h0;
            next_s.x = flip ? -xe : xe;
            next_s.y = flip ? -ye : ye;
            next_s.z = -$signed({red[7:0], 8'h00});
        end else if (s.busy) begin
            if (!s.z[15]) begin
                next_s.x = s.x - sy;
                next_s.y = s.y + sx;
                next_s.z = s.z - atan_q8(s.iter);
            end else begin
                next_s.x = s.x + sy;
                next_s.y = s.y - sx;
                next_s.z = s.z + atan_q8(s.iter);
            end
            next_s.iter = s.iter + 4'h1;
            if (s.iter == 4'(CORDIC_N - 1)) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy = s.busy;
    assign done = s.done;
    assign proj = s.x;

    a_cordic_len: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (start && !busy) |-> ##1 !done ##12 done)
        else $error("projection not done after twelve steps");
endmodule

// ==== verilog/dup_directional_underpower_element.sv ====
// Directional under-power element: decision, hysteresis, timer, events
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module dup_directional_underpower_element #(
    parameter int W        = 16,
    parameter int PW       = 24,
    parameter int SHIFT    = 8,
    parameter int TICK_CYC = dup_pkg::TICK_CYCLES
) (
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    input  wire logic                       sample_valid,
    input  wire logic signed [2:0][W-1:0]   u_re,
    input  wire logic signed [2:0][W-1:0]   u_im,
    input  wire logic signed [2:0][W-1:0]   i_re,
    input  wire logic signed [2:0][W-1:0]   i_im,
    input  wire logic                       general_block_in,
    input  wire logic                       vt_supervision_block_in,
    input  wire logic [dup_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [dup_pkg::REG_DW-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [dup_pkg::REG_DW-1:0]      reg_rdata,
    output logic                            general_start_out,
    output logic                            general_trip_out,
    output logic                            irq
);
    import dup_pkg::*;

    localparam int XW  = PW + 2;
    localparam int PTW = $clog2(TICK_CYC) + 1;
    localparam logic [PTW-1:0] TICK_LAST = PTW'(TICK_CYC - 1);

    typedef struct packed {
        logic                 op_on;
        logic                 start_only;
        logic signed [8:0]    angle;
        logic [10:0]          start_pwr;
        logic [15:0]          delay;
        logic [EV_W-1:0]      mask;
        logic [EV_W-1:0]      evt;
        logic [REG_DW-1:0]    rd_data;
        logic signed [XW-1:0] proj;
        logic                 dir;
        logic                 start;
        logic                 trip;
        logic [PTW-1:0]       prescale;
        logic [15:0]          ms_cnt;
        logic                 irq;
    } dup_state_t;

    dup_state_t           s;
    dup_state_t           next_s;
    logic signed [PW-1:0] pq_p;
    logic signed [PW-1:0] pq_q;
    logic                 pq_valid;
    logic                 cor_go;
    logic                 cor_busy;
    logic                 cor_done;
    logic signed [XW-1:0] cor_proj;
    logic signed [XW-1:0] thr_lo;
    logic signed [XW-1:0] thr_hi;
    logic [31:0]          hyst_w;
    logic [31:0]          lo_k_w;
    logic [31:0]          hi_k_w;
    logic signed [31:0]   wsig;
    logic [EV_W-1:0]      ev_set;
    logic [EV_W-1:0]      ev_clr;

    dup_pq #(
        .W     (W),
        .PW    (PW),
        .SHIFT (SHIFT)
    ) u_pq (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (sample_valid),
        .u_re      (u_re),
        .u_im      (u_im),
        .i_re      (i_re),
        .i_im      (i_im),
        .out_valid (pq_valid),
        .p         (pq_p),
        .q         (pq_q)
    );

    // A sample that lands while a projection runs is skipped; the
    // measurement rate is far below one sample per projection
    assign cor_go = pq_valid & ~cor_busy;

    dup_proj #(
        .PW (PW)
    ) u_proj (
        .mclk  (mclk),
        .rst_n (rst_n),
        .start (cor_go),
        .x_in  (pq_p),
        .y_in  (pq_q),
        .angle (s.angle),
        .busy  (cor_busy),
        .done  (cor_done),
        .proj  (cor_proj)
    );

    // Thresholds in tenths of a percent, scaled by the rotation gain
    assign hyst_w = ({21'h0, s.start_pwr} * HYST_NUM) >> HYST_SHIFT;
    assign lo_k_w = ({21'h0, s.start_pwr} * GAIN_NUM) >> GAIN_SHIFT;
    assign hi_k_w = (({21'h0, s.start_pwr} + hyst_w) * GAIN_NUM)
                    >> GAIN_SHIFT;
    assign thr_lo = $signed({1'b0, lo_k_w[XW-2:0]});
    assign thr_hi = $signed({1'b0, hi_k_w[XW-2:0]});
    assign wsig   = $signed(reg_wdata);

    always_comb begin
        next_s = s;
        next_s.rd_data = '0;
        ev_set = '0;
        ev_clr = '0;
        if (reg_wr) begin
            case (reg_addr)
                A_CTRL: begin
                    next_s.op_on = reg_wdata[CTRL_OP];
                    next_s.start_only = reg_wdata[CTRL_SO];
                end
                A_ANGLE: begin
                    if (wsig < int'(ANG_MIN)) begin
                        next_s.angle = ANG_MIN;
                    end else if (wsig > int'(ANG_MAX)) begin
                        next_s.angle = ANG_MAX;
                    end else begin
                        next_s.angle = reg_wdata[8:0];
                    end
                end
                A_POWER: begin
                    if (reg_wdata < 32'(PWR_MIN)) begin
                        next_s.start_pwr = PWR_MIN;
                    end else if (reg_wdata > 32'(PWR_MAX)) begin
                        next_s.start_pwr = PWR_MAX;
                    end else begin
                        next_s.start_pwr = reg_wdata[10:0];
                    end
                end
                A_DELAY: begin
                    if (reg_wdata < 32'(DLY_MIN)) begin
                        next_s.delay = DLY_MIN;
                    end else if (reg_wdata > 32'(DLY_MAX)) begin
                        next_s.delay = DLY_MAX;
                    end else begin
                        next_s.delay = reg_wdata[15:0];
                    end
                end
                A_EVENT: begin
                    ev_clr = reg_wdata[EV_W-1:0];
                end
                A_MASK: begin
                    next_s.mask = reg_wdata[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                A_CTRL: begin
                    next_s.rd_data[CTRL_OP] = s.op_on;
                    next_s.rd_data[CTRL_SO] = s.start_only;
                end
                A_ANGLE: begin
                    next_s.rd_data = 32'(s.angle);
                end
                A_POWER: begin
                    next_s.rd_data = 32'(s.start_pwr);
                end
                A_DELAY: begin
                    next_s.rd_data = 32'(s.delay);
                end
                A_STATUS: begin
                    next_s.rd_data[ST_START] = s.start;
                    next_s.rd_data[ST_TRIP] = s.trip;
                    next_s.rd_data[ST_DIR] = s.dir;
                end
                A_EVENT: begin
                    next_s.rd_data = 32'(s.evt);
                end
                A_MASK: begin
                    next_s.rd_data = 32'(s.mask);
                end
                A_TIMER: begin
                    next_s.rd_data = 32'(s.ms_cnt);
                end
                A_PROJ: begin
                    next_s.rd_data = 32'(s.proj);
                end
                default: begin
                    next_s.rd_data = '0;
                end
            endcase
        end

        // Operate side: projection onto the direction below threshold
        if (!s.op_on) begin
            next_s.dir = 1'b0;
        end else if (cor_done) begin
            next_s.proj = cor_proj;
            if (s.dir) begin
                next_s.dir = cor_proj < thr_hi;
            end else begin
                next_s.dir = cor_proj < thr_lo;
            end
        end
        next_s.start = s.op_on & next_s.dir & ~general_block_in
                       & ~vt_supervision_block_in;

        // Millisecond tick counter; stops once the delay is reached
        if (!next_s.start || s.start_only) begin
            next_s.prescale = '0;
            next_s.ms_cnt = 16'h0000;
            next_s.trip = 1'b0;
        end else begin
            if (s.ms_cnt < s.delay) begin
                if (s.prescale == TICK_LAST) begin
                    next_s.prescale = '0;
                    next_s.ms_cnt = s.ms_cnt + 16'h0001;
                end else begin
                    next_s.prescale = s.prescale + PTW'(1);
                end
            end
            next_s.trip = s.ms_cnt >= s.delay;
        end

        ev_set[EV_START_ON] = next_s.start & ~s.start;
        ev_set[EV_START_OFF] = ~next_s.start & s.start;
        ev_set[EV_TRIP_ON] = next_s.trip & ~s.trip;
        ev_set[EV_TRIP_OFF] = ~next_s.trip & s.trip;
        // A new event outranks a clear in the same cycle
        next_s.evt = (s.evt & ~ev_clr) | ev_set;
        next_s.irq = |(next_s.evt & next_s.mask);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
            s.op_on <= RST_OP;
            s.start_only <= RST_SO;
            s.angle <= ANG_RST;
            s.start_pwr <= PWR_RST;
            s.delay <= DLY_RST;
            s.mask <= MASK_RST;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata         = s.rd_data;
    assign general_start_out = s.start;
    assign general_trip_out  = s.trip;
    assign irq               = s.irq;

    a_off_quiet: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !s.op_on |=> !general_start_out && !general_trip_out
                     && s.ms_cnt == 16'h0000)
        else $error("outputs or timer active while off");

    a_start_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        general_start_out |-> s.dir && $past(s.op_on)
            && !$past(general_block_in)
            && !$past(vt_supervision_block_in))
        else $error("start without direction or while blocked");

    a_dir_set: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (s.op_on && cor_done && !s.dir && cor_proj >= thr_lo)
        |=> !s.dir)
        else $error("direction set above start power");

    a_hyst_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (s.op_on && cor_done && s.dir && cor_proj < thr_hi) |=> s.dir)
        else $error("direction dropped inside hysteresis band");

    a_trip_delay: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $rose(general_trip_out) |-> general_start_out
            && $past(s.ms_cnt) >= $past(s.delay))
        else $error("trip before the delay expired");

    a_tick_rate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (s.ms_cnt != $past(s.ms_cnt) && s.ms_cnt != 16'h0000)
        |-> $past(s.prescale) == TICK_LAST && s.prescale == '0)
        else $error("millisecond tick at wrong rate");

    a_trip_gate: assert property (
        @(posedge mclk) disable iff (!rst_n)
        general_trip_out |-> general_start_out && !$past(s.start_only))
        else $error("trip while start only or without start");

    a_drop_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(general_start_out) |-> !general_trip_out
                                     && s.ms_cnt == 16'h0000)
        else $error("timer survived start dropout");

    a_setting_range: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s.angle >= ANG_MIN && s.angle <= ANG_MAX
        && s.start_pwr >= PWR_MIN && s.start_pwr <= PWR_MAX
        && s.delay >= DLY_MIN && s.delay <= DLY_MAX)
        else $error("setting outside its range");

    a_event_edges: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ($rose(general_start_out) |-> s.evt[EV_START_ON])
        and ($fell(general_trip_out) |-> s.evt[EV_TRIP_OFF]))
        else $error("output edge did not raise its event");

    a_irq_level: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ((s.evt & s.mask) != '0) |-> irq)
        else $error("unmasked event without interrupt");
endmodule

// ==== bench/dup_meas_model.sv ====
// Partner model: phasor source standing in for the measurement logic
`timescale 1ns/1ns
module dup_meas_model (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                high_load,
    output logic                     sample_valid,
    output logic signed [2:0][15:0]  u_re,
    output logic signed [2:0][15:0]  u_im,
    output logic signed [2:0][15:0]  i_re,
    output logic signed [2:0][15:0]  i_im
);
    logic [4:0] cnt;

    // One sample every 20 cycles, wider than the 13-cycle projection spacing
    always_ff @(posedge mclk) begin
        cnt          <= (!rst_n || cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
        sample_valid <= rst_n && cnt == 5'h00;
        if (rst_n && cnt == 5'h00) begin
            u_re <= {3{16'sh03e8}};
            u_im <= '0;
            i_re <= high_load ? {3{16'sh03e8}} : '0;
            i_im <= '0;
        end else begin
            // Data outside the valid cycle is scrambled, never held
            u_re <= ~u_re;
            u_im <= ~u_im;
            i_re <= ~i_re;
            i_im <= ~i_im;
        end
    end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the directional under-power element
`timescale 1ns/1ns
module tb;
    import dup_pkg::*;
    logic                   mclk, rst_n, sv, high_load, blk, vtb;
    logic                   reg_wr, reg_rd, start_o, trip_o, irq;
    logic [3:0]             reg_addr;
    logic [31:0]            reg_wdata, reg_rdata, rv;
    logic signed [2:0][15:0] ur, ui, ir, ii;
    int                     n_errors, n_checks, n;

    dup_meas_model MEAS (.mclk(mclk), .rst_n(rst_n), .high_load(high_load),
        .sample_valid(sv), .u_re(ur), .u_im(ui), .i_re(ir), .i_im(ii));
    dup_directional_underpower_element #(.TICK_CYC(4)) DUT (
        .mclk(mclk), .rst_n(rst_n), .sample_valid(sv), .u_re(ur),
        .u_im(ui), .i_re(ir), .i_im(ii), .general_block_in(blk),
        .vt_supervision_block_in(vtb), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .general_start_out(start_o),
        .general_trip_out(trip_o), .irq(irq));

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // Bounded wait for start (sel 0) or trip (sel 1) to reach level e
    task automatic wait_for(input bit sel, input logic e, input int bound);
        n = 0;
        while ((sel ? trip_o : start_o) !== e) begin
            @(posedge mclk);
            #1 n++;
            if (n > bound) begin
                chk({31'h0, sel ? trip_o : start_o}, {31'h0, e});
                final_report();
            end
        end
    endtask

    task automatic t_reset();
        rd(A_CTRL);  chk(rv, 32'h0);
        rd(A_ANGLE); chk(rv, 32'h0);
        rd(A_POWER); chk(rv, 32'h64);
        rd(A_DELAY); chk(rv, 32'hc8);
        rd(A_MASK);  chk(rv, 32'h0);
        rd(4'hf);    chk(rv, 32'h0);
        $display("done reset");
    endtask

    task automatic t_clamp();
        wr(A_ANGLE, 32'hc8);   rd(A_ANGLE); chk(rv, 32'hb4);
        wr(A_ANGLE, 32'hffffff38);
        rd(A_ANGLE); chk(rv, 32'hffffff4d);
        wr(A_POWER, 32'h0);    rd(A_POWER); chk(rv, 32'ha);
        wr(A_POWER, 32'h1388); rd(A_POWER); chk(rv, 32'h7d0);
        wr(A_DELAY, 32'h0);    rd(A_DELAY); chk(rv, 32'hc8);
        wr(A_ANGLE, 32'h0);
        wr(A_POWER, 32'h64);
        $display("done clamp");
    endtask

    task automatic t_off_then_trip();
        // Low power present while off: outputs must stay quiet
        repeat (45) @(posedge mclk);
        chk({30'h0, start_o, trip_o}, 32'h0);
        wr(A_MASK, 32'h1);
        wr(A_CTRL, 32'h1);
        wait_for(0, 1'b1, 60);
        chk({31'h0, irq}, 32'h1);
        wait_for(1, 1'b1, 900);
        chk(n, 800);
        rd(A_EVENT); chk(rv, 32'h5);
        wr(A_EVENT, 32'hf);
        rd(A_EVENT); chk(rv, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("done trip");
    endtask

    task automatic t_block();
        @(posedge mclk) blk <= 1'b1;
        wait_for(0, 1'b0, 3);
        chk({31'h0, trip_o}, 32'h0);
        @(posedge mclk) blk <= 1'b0;
        wait_for(0, 1'b1, 60);
        @(posedge mclk) vtb <= 1'b1;
        wait_for(0, 1'b0, 3);
        @(posedge mclk) vtb <= 1'b0;
        $display("done block");
    endtask

    task automatic t_dropout();
        wait_for(0, 1'b1, 60);
        repeat (100) @(posedge mclk);
        @(posedge mclk) high_load <= 1'b1;
        wait_for(0, 1'b0, 60);
        repeat (850) @(posedge mclk);
        chk({31'h0, trip_o}, 32'h0);
        rd(A_TIMER); chk(rv, 32'h0);
        rd(A_EVENT); chk(rv[1:0], 32'h3);
        wr(A_ANGLE, 32'hb4);
        wait_for(0, 1'b1, 60);
        wr(A_ANGLE, 32'h0);
        wait_for(0, 1'b0, 60);
        $display("done dropout");
    endtask

    task automatic t_start_only();
        wr(A_CTRL, 32'h3);
        @(posedge mclk) high_load <= 1'b0;
        wait_for(0, 1'b1, 60);
        repeat (900) @(posedge mclk);
        chk({30'h0, start_o, trip_o}, 32'h2);
        rd(A_STATUS); chk(rv, 32'h5);
        rd(A_PROJ);   chk(rv, 32'h0);
        wr(A_CTRL, 32'h0);
        wait_for(0, 1'b0, 3);
        $display("done start only");
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        rst_n = 1'b0; high_load = 1'b0; blk = 1'b0; vtb = 1'b0;
        reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
        n_errors = 0; n_checks = 0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_clamp();
        t_off_then_trip();
        t_block();
        t_dropout();
        t_start_only();
        final_report();
    end
endmodule
